/* File: pfs_params.svh */
// Purpose: offsets, field positions and reset values for the fault summary byte
// Assumes: command codes are the PMBus command byte values
// Notes: included by the design module only
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH
`define PFS_CMD_SUMMARY_BYTE 8'h78
`define PFS_CMD_STATUS_WORD 8'h79
`define PFS_BIT_NOT_CONVERTING 6
`define PFS_BIT_OVERVOLTAGE 5
`define PFS_BIT_OVERCURRENT 4
`define PFS_BIT_UNSUPPORTED_HI 7
`define PFS_BIT_UNSUPPORTED_LO 3
`define PFS_BIT_TEMPERATURE 2
`define PFS_BIT_COMM_MEM_LOGIC 1
`define PFS_BIT_MISC 0
`define PFS_SUMMARY_RESET 8'h40
`endif

/* File: pfs_pkg.sv */
// Purpose: types for the fault summary byte
// Assumes: nothing beyond the params header
// Notes: source status bits travel as one packed struct
package pfs_pkg;
	typedef struct packed {
		logic not_converting;
		logic output_overvoltage_fault;
		logic output_overcurrent_fault;
		logic overcurrent_undervoltage_fault;
		logic temp_overtemp_fault;
		logic temp_overtemp_warning;
		logic cml_any_fault;
		logic output_limit_warning;
		logic bandgap_overtemp_fault;
		logic low_input;
		logic output_undervoltage_fault;
		logic overcurrent_warning;
		logic overvoltage_warning;
		logic undervoltage_warning;
		logic power_input_overvoltage_fault;
		logic first_alert_event;
	} pfs_sources_type;

	typedef enum logic [1:0] {
		PFS_ACC_NONE,
		PFS_ACC_READ,
		PFS_ACC_WRITE
	} pfs_access_type;
endpackage

/* File: pfs_fault_summary.sv */
// Purpose: read-only fault summary byte for the PMBus status system
// Assumes: transaction engine presents a decoded command with one-cycle strobes
// Notes: alert masking lives in the detailed status registers, not here
`timescale 1ns/1ps
`include "pfs_params.svh"
module pfs_fault_summary
(
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic I_IS_SECONDARY,
	input wire pfs_pkg::pfs_sources_type I_SOURCES,
	input wire logic [7:0] I_CMD_CODE,
	input wire logic I_CMD_READ,
	input wire logic I_CMD_WRITE,
	output logic [7:0] O_READ_DATA,
	output logic O_READ_VALID,
	output logic O_CMD_HIT,
	output logic O_INVALID_DATA,
	output logic [7:0] O_SUMMARY_BYTE
);
	logic [7:0] summary_reg;
	logic [7:0] summary_next;
	logic [7:0] read_data_reg;
	logic read_valid_reg;
	logic invalid_reg;
	pfs_pkg::pfs_access_type access;

	function automatic logic is_status_cmd(input logic [7:0] code);
		is_status_cmd = (code == `PFS_CMD_SUMMARY_BYTE) || (code == `PFS_CMD_STATUS_WORD);
	endfunction

	// pure combination of sources; no latch so a cleared source clears the bit next cycle
	always_comb
	begin
		summary_next = 8'h00;
		summary_next[`PFS_BIT_NOT_CONVERTING] = I_SOURCES.not_converting;
		summary_next[`PFS_BIT_OVERVOLTAGE] = I_SOURCES.output_overvoltage_fault;
		summary_next[`PFS_BIT_OVERCURRENT] = I_SOURCES.output_overcurrent_fault
			| I_SOURCES.overcurrent_undervoltage_fault;
		summary_next[`PFS_BIT_TEMPERATURE] = I_SOURCES.temp_overtemp_fault
			| I_SOURCES.temp_overtemp_warning;
		summary_next[`PFS_BIT_COMM_MEM_LOGIC] = I_SOURCES.cml_any_fault;
		summary_next[`PFS_BIT_MISC] = I_SOURCES.output_limit_warning
			| I_SOURCES.bandgap_overtemp_fault | I_SOURCES.low_input
			| I_SOURCES.output_undervoltage_fault | I_SOURCES.overcurrent_warning
			| I_SOURCES.overvoltage_warning | I_SOURCES.undervoltage_warning
			| I_SOURCES.power_input_overvoltage_fault
			| I_SOURCES.first_alert_event;
		summary_next[`PFS_BIT_UNSUPPORTED_HI] = 1'b0;
		summary_next[`PFS_BIT_UNSUPPORTED_LO] = 1'b0;
		if (I_IS_SECONDARY)
		begin
			summary_next = 8'h00;
		end
	end

	// summary tracks sources each clock, one cycle of latency
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			summary_reg <= `PFS_SUMMARY_RESET;
		end
		else
		begin
			summary_reg <= summary_next;
		end
	end

	always_comb
	begin
		access = pfs_pkg::PFS_ACC_NONE;
		if (is_status_cmd(I_CMD_CODE) && I_CMD_WRITE)
		begin
			access = pfs_pkg::PFS_ACC_WRITE;
		end
		else if ((I_CMD_CODE == `PFS_CMD_SUMMARY_BYTE) && I_CMD_READ)
		begin
			access = pfs_pkg::PFS_ACC_READ;
		end
	end

	// read returns the same register the status word low byte uses
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			read_data_reg <= 8'h00;
			read_valid_reg <= 1'b0;
		end
		else
		begin
			read_valid_reg <= 1'b0;
			case (access)
				pfs_pkg::PFS_ACC_READ:
				begin
					read_data_reg <= summary_reg;
					read_valid_reg <= 1'b1;
				end
				default:
				begin
					read_data_reg <= read_data_reg;
				end
			endcase
		end
	end

	// write data is dropped; pulse tells the engine to nack and set its invalid-data flag
	always_ff @(posedge I_REF_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			invalid_reg <= 1'b0;
		end
		else
		begin
			invalid_reg <= (access == pfs_pkg::PFS_ACC_WRITE);
		end
	end

	assign O_READ_DATA = read_data_reg;
	assign O_READ_VALID = read_valid_reg;
	assign O_CMD_HIT = is_status_cmd(I_CMD_CODE) && (I_CMD_READ || I_CMD_WRITE);
	assign O_INVALID_DATA = invalid_reg;
	assign O_SUMMARY_BYTE = summary_reg;

	a_reserved_bits_zero: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!summary_reg[`PFS_BIT_UNSUPPORTED_HI] && !summary_reg[`PFS_BIT_UNSUPPORTED_LO])
		else $error("unsupported summary bit set");
	a_secondary_zero: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		I_IS_SECONDARY |=> (summary_reg == 8'h00))
		else $error("secondary summary not zero");
	a_off_follows: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!I_IS_SECONDARY |=> summary_reg[`PFS_BIT_NOT_CONVERTING]
		== $past(I_SOURCES.not_converting))
		else $error("not converting bit wrong");
	a_ovf_mirror: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!I_IS_SECONDARY |=> summary_reg[`PFS_BIT_OVERVOLTAGE]
		== $past(I_SOURCES.output_overvoltage_fault))
		else $error("overvoltage mirror wrong");
	a_ocf_or: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.overcurrent_undervoltage_fault)
		|=> summary_reg[`PFS_BIT_OVERCURRENT])
		else $error("overcurrent bit missed");
	a_temp_or: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.temp_overtemp_warning)
		|=> summary_reg[`PFS_BIT_TEMPERATURE])
		else $error("temperature bit missed");
	a_cml_clear: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!I_SOURCES.cml_any_fault |=> !summary_reg[`PFS_BIT_COMM_MEM_LOGIC])
		else $error("cml bit did not clear");
	a_misc_or: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.first_alert_event)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc bit missed");
	a_read_value: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(access == pfs_pkg::PFS_ACC_READ) |=> O_READ_VALID && (O_READ_DATA == $past(summary_reg)))
		else $error("read data wrong");
	a_write_flagged: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(I_CMD_WRITE && is_status_cmd(I_CMD_CODE)) |=> O_INVALID_DATA && !O_READ_VALID)
		else $error("write not rejected");

	// each misc source gets its own check so a dropped term in the wide OR shows up
	a_ovf_clear: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		!I_SOURCES.output_overvoltage_fault
		|=> !summary_reg[`PFS_BIT_OVERVOLTAGE])
		else $error("overvoltage bit did not clear");

	a_ocf_fault_or: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.output_overcurrent_fault)
		|=> summary_reg[`PFS_BIT_OVERCURRENT])
		else $error("overcurrent fault missed");

	a_ocf_clear: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_SOURCES.output_overcurrent_fault && !I_SOURCES.overcurrent_undervoltage_fault)
		|=> !summary_reg[`PFS_BIT_OVERCURRENT])
		else $error("overcurrent bit did not clear");

	a_temp_fault_or: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.temp_overtemp_fault)
		|=> summary_reg[`PFS_BIT_TEMPERATURE])
		else $error("temperature fault missed");

	a_temp_clear: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_SOURCES.temp_overtemp_fault && !I_SOURCES.temp_overtemp_warning)
		|=> !summary_reg[`PFS_BIT_TEMPERATURE])
		else $error("temperature bit did not clear");

	a_cml_set: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.cml_any_fault)
		|=> summary_reg[`PFS_BIT_COMM_MEM_LOGIC])
		else $error("cml bit missed");

	a_misc_limit: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.output_limit_warning)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc limit warning missed");

	a_misc_bandgap: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.bandgap_overtemp_fault)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc bandgap fault missed");

	a_misc_low_input: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.low_input)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc low input missed");

	a_misc_undervolt: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.output_undervoltage_fault)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc undervoltage fault missed");

	a_misc_oc_warn: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.overcurrent_warning)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc overcurrent warning missed");

	a_misc_ov_warn: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.overvoltage_warning)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc overvoltage warning missed");

	a_misc_uv_warn: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.undervoltage_warning)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc undervoltage warning missed");

	a_misc_pvin: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_IS_SECONDARY && I_SOURCES.power_input_overvoltage_fault)
		|=> summary_reg[`PFS_BIT_MISC])
		else $error("misc input overvoltage missed");

	a_misc_clear: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(I_SOURCES[8:0] == 9'h000)
		|=> !summary_reg[`PFS_BIT_MISC])
		else $error("misc bit did not clear");

	a_read_holds: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(access != pfs_pkg::PFS_ACC_READ)
		|=> $stable(O_READ_DATA))
		else $error("read data moved without a read");

	a_read_silent: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(access != pfs_pkg::PFS_ACC_READ)
		|=> !O_READ_VALID)
		else $error("read valid without a read");

	a_invalid_only: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(access != pfs_pkg::PFS_ACC_WRITE)
		|=> !O_INVALID_DATA)
		else $error("invalid data without a write");

	a_word_read_silent: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(I_CMD_READ && !I_CMD_WRITE && (I_CMD_CODE == `PFS_CMD_STATUS_WORD))
		|=> !O_READ_VALID)
		else $error("word read answered here");

	a_read_reserved: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		O_READ_VALID
		|-> !O_READ_DATA[`PFS_BIT_UNSUPPORTED_HI] && !O_READ_DATA[`PFS_BIT_UNSUPPORTED_LO])
		else $error("unsupported bit read as one");

	a_secondary_read: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		I_IS_SECONDARY ##1 (access == pfs_pkg::PFS_ACC_READ)
		|=> (O_READ_DATA == 8'h00))
		else $error("secondary read not zero");

	a_hit_word_write: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(I_CMD_WRITE && (I_CMD_CODE == `PFS_CMD_STATUS_WORD))
		|-> O_CMD_HIT)
		else $error("word write not claimed");

	a_hit_byte_read: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(I_CMD_READ && (I_CMD_CODE == `PFS_CMD_SUMMARY_BYTE))
		|-> O_CMD_HIT)
		else $error("byte read not claimed");

	a_hit_idle: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
		(!I_CMD_READ && !I_CMD_WRITE)
		|-> !O_CMD_HIT)
		else $error("command claimed without strobe");

	c_read: cover property (@(posedge I_REF_CLK) disable iff (I_RESET) O_READ_VALID);
	c_write_byte: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
		I_CMD_WRITE && (I_CMD_CODE == `PFS_CMD_SUMMARY_BYTE));
	c_write_word: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
		I_CMD_WRITE && (I_CMD_CODE == `PFS_CMD_STATUS_WORD));
	c_secondary: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
		I_IS_SECONDARY && I_SOURCES.output_overvoltage_fault);
	c_misc_only: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
		summary_reg == 8'h01);
endmodule

/* File: pfs_host_model.sv */
// Purpose: host controller model that issues decoded summary byte commands
// Assumes: strobes change at the falling edge and last one clock
// Notes: the code lines are inverted after release so stale values cannot help
`timescale 1ns/1ps
module pfs_host_model
(
	input wire logic i_clk,
	output logic [7:0] o_cmd_code,
	output logic o_cmd_read,
	output logic o_cmd_write
);
	initial
	begin
		o_cmd_code = 8'h00;
		o_cmd_read = 1'h0;
		o_cmd_write = 1'h0;
	end
	// single byte access, one strobe per transaction
	task automatic access(input logic [7:0] code, input logic wr);
		@(negedge i_clk);
		o_cmd_code = code;
		o_cmd_read = !wr;
		o_cmd_write = wr;
		@(negedge i_clk);
		o_cmd_read = 1'h0;
		o_cmd_write = 1'h0;
		o_cmd_code = ~code;
	endtask
endmodule

/* File: pfs_fault_summary_tb_top.sv */
// Purpose: self-checking bench for the fault summary byte
// Assumes: summary and answers land one clock after their cause
// Notes: misc sources walked one at a time so a missing OR term shows
`timescale 1ns/1ps
module pfs_fault_summary_tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic is_sec = 1'h0;
	pfs_pkg::pfs_sources_type sources = '0;
	logic [7:0] cmd_code;
	logic cmd_read;
	logic cmd_write;
	logic [7:0] read_data;
	logic read_valid;
	logic invalid_data;
	logic cmd_hit;
	logic [7:0] summary;
	int num_errors = 0;
	int checks = 0;
	int cycle_count = 0;
	// source bits, secondary flag, expected summary
	logic [24:0] rows [10] = '{{16'h0000, 1'h0, 8'h00}, {16'h8000, 1'h0, 8'h40},
		{16'h4000, 1'h0, 8'h20}, {16'h2000, 1'h0, 8'h10}, {16'h1000, 1'h0, 8'h10},
		{16'h0800, 1'h0, 8'h04}, {16'h0400, 1'h0, 8'h04}, {16'h0200, 1'h0, 8'h02},
		{16'hffff, 1'h0, 8'h77}, {16'hffff, 1'h1, 8'h00}};
	pfs_host_model u_pfs_host_model (.i_clk(clk), .o_cmd_code(cmd_code),
		.o_cmd_read(cmd_read), .o_cmd_write(cmd_write));
	pfs_fault_summary u_pfs_fault_summary (.I_REF_CLK(clk), .I_RESET(rst),
		.I_IS_SECONDARY(is_sec), .I_SOURCES(sources), .I_CMD_CODE(cmd_code),
		.I_CMD_READ(cmd_read), .I_CMD_WRITE(cmd_write), .O_READ_DATA(read_data),
		.O_READ_VALID(read_valid), .O_CMD_HIT(cmd_hit), .O_INVALID_DATA(invalid_data),
		.O_SUMMARY_BYTE(summary));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task apply(input logic [15:0] src, input logic sec);
		@(negedge clk);
		sources = src;
		is_sec = sec;
		@(negedge clk);
	endtask
	// claim flag is combinational, so look at it while the strobe stands
	always @(posedge clk)
	begin
		if (!rst && (cmd_read || cmd_write))
		begin
			check({7'h00, cmd_hit}, {7'h00, (cmd_code == 8'h78) || (cmd_code == 8'h79)});
		end
	end
	// hang guard well above the roughly 90 cycles the tests need
	always @(posedge clk)
	begin
		cycle_count++;
		if (cycle_count == 5000)
		begin
			num_errors++;
			results;
		end
	end
	initial
	begin
		repeat (2) @(negedge clk);
		check(summary, 8'h40);
		check(read_data, 8'h00);
		rst = 1'h0;
		$display("test reset done");
		foreach (rows[i])
		begin
			apply(rows[i][24:9], rows[i][8]);
			check(summary, rows[i][7:0]);
			u_pfs_host_model.access(8'h78, 1'h0);
			check({7'h00, read_valid}, 8'h01);
			check(read_data, rows[i][7:0]);
			apply(16'h0000, 1'h0);
			check(summary, 8'h00);
		end
		$display("test table done");
		for (int b = 0; b < 9; b++)
		begin
			apply(16'h0001 << b, 1'h0);
			check(summary, 8'h01);
		end
		u_pfs_host_model.access(8'h78, 1'h0);
		check(read_data, 8'h01);
		$display("test misc done");
		u_pfs_host_model.access(8'h78, 1'h1);
		check({6'h00, invalid_data, read_valid}, 8'h02);
		u_pfs_host_model.access(8'h79, 1'h1);
		check({6'h00, invalid_data, read_valid}, 8'h02);
		u_pfs_host_model.access(8'h79, 1'h0);
		check({6'h00, invalid_data, read_valid}, 8'h00);
		u_pfs_host_model.access(8'h7a, 1'h0);
		check({6'h00, invalid_data, read_valid}, 8'h00);
		check(read_data, 8'h01);
		$display("test commands done");
		results;
	end
endmodule
